// [ptq_afe.sv]
`timescale 1ns/1ps
`default_nettype none
module ptq_afe #(
    parameter logic [7:0] LVL = 8'h80,
    parameter logic [7:0] LOW = 8'h40,
    parameter logic [7:0] UP  = 8'hc0
) (
    // Analog level per channel
    input  wire logic [7:0] v_i   [4],
    // Comparator pins: level, lower, upper
    output var  logic [2:0] cmp_o [4]
);
    // Comparators drive their outputs at all times, so nothing floats
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            cmp_o[i] = {v_i[i] > UP, v_i[i] > LOW, v_i[i] > LVL};
        end
    end
endmodule // ptq_afe
`default_nettype wire

// [ptq_pkg.sv]
`default_nettype none
package ptq_pkg;

    // ********************************************************
    // Modes
    // ********************************************************
    typedef enum logic [1:0] {
        PTQ_GLITCH,
        PTQ_RUNT,
        PTQ_WIDTH
    } ptq_class_t;

    typedef enum logic [1:0] {
        PTQ_POS,
        PTQ_NEG,
        PTQ_EITHER
    } ptq_pol_t;

    // ********************************************************
    // Source select codes and comparator field positions
    // ********************************************************
    localparam logic [1:0] SRC_ONE   = 2'h0;
    localparam logic [1:0] SRC_TWO   = 2'h1;
    localparam logic [1:0] SRC_THREE = 2'h2;
    localparam logic [1:0] SRC_FOUR  = 2'h3;
    localparam int CMP_W   = 3;
    localparam int CMP_LVL = 0;
    localparam int CMP_LOW = 1;
    localparam int CMP_UP  = 2;

    // ********************************************************
    // Values after reset and percentages
    // ********************************************************
    localparam int PCT_W         = 8;
    localparam logic [7:0] PCT_MAX       = 8'h64;
    localparam logic [7:0] HOLDOFF_RST   = 8'h00;
    localparam logic [7:0] AUTO_WAIT_PCT = 8'h64;
    localparam int UPPER_RST = 65535;
    localparam int LOWER_RST = 0;
    localparam int LEVEL_RST = 128;
    localparam int CNT_START = 1;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_MHZ       = 20;
    localparam int MID_SEARCH_NS = 100000;
    localparam int MID_SEARCH_CYC =
        (MID_SEARCH_NS * CLK_MHZ + 999) / 1000;
    localparam int MID_CW = $clog2(MID_SEARCH_CYC + 1);

endpackage
`default_nettype wire

// [ptq_qualifier.sv]
`timescale 1ns/1ps
`default_nettype none
// How it works
// (R1) One of four channels feeds the qualifier
// (R2) Auto mode acquires after time base wait
// (R3) Normal mode acquires only on triggers or force
// (R4) Force starts exactly one acquisition
// (R5) Holdoff kept in percent delays re-arming
// (R6) Glitch polarity: positive, negative or either
// (R7) Glitch accept: no wider than glitch width
// (R8) Glitch reject: wider than glitch width
// (R9) Midpoint request sets level between peaks
// (R10) Runt keeps upper and lower thresholds
// (R11) Positive runt: lower up, down, no upper
// (R12) Negative runt: upper down, up, no lower
// (R13) Either runt: cross, recross, other untouched
// (R14) Runt fires at recrossing of first threshold
// (R15) Width polarity is positive or negative only
// (R16) Within limits: lower to upper inclusive
// (R17) Out of limits: outside lower to upper
// (R18) Upper is maximum, lower is minimum width
// (R19) Lower limit clamped to upper on writes
// (R20) Classes are glitch, runt and width
// (R21) Widths in clocks, equal counts as inside
module ptq_qualifier #(
    parameter int WW = 16,
    parameter int SW = 8,
    parameter int TW = 16
) (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rstn_i,
    // Comparator pins: level, lower, upper
    input  wire logic [2:0]           input_channel_one_i,
    input  wire logic [2:0]           input_channel_two_i,
    input  wire logic [2:0]           input_channel_three_i,
    input  wire logic [2:0]           input_channel_four_i,
    // Digitizer samples on clk_i
    input  wire logic [SW-1:0]        input_channel_one_samp_i,
    input  wire logic [SW-1:0]        input_channel_two_samp_i,
    input  wire logic [SW-1:0]        input_channel_three_samp_i,
    input  wire logic [SW-1:0]        input_channel_four_samp_i,
    // Configuration levels
    input  wire logic [1:0]           source_i,
    input  wire ptq_pkg::ptq_class_t  class_i,
    input  wire ptq_pkg::ptq_pol_t    polarity_i,
    input  wire logic                 glitch_reject_i,
    input  wire logic [WW-1:0]        glitch_width_i,
    input  wire logic                 width_outside_i,
    input  wire logic                 auto_mode_i,
    input  wire logic [TW-1:0]        timebase_i,
    // Setting writes
    input  wire logic                 holdoff_wr_i,
    input  wire logic [7:0]           holdoff_pct_i,
    input  wire logic                 upper_wr_i,
    input  wire logic [WW-1:0]        upper_val_i,
    input  wire logic                 lower_wr_i,
    input  wire logic [WW-1:0]        lower_val_i,
    // Requests
    input  wire logic                 force_i,
    input  wire logic                 mid_req_i,
    // Acquisition control
    output var  logic                 trig_o,
    output var  logic                 acq_start_o,
    output var  logic                 auto_acq_o,
    output var  logic                 forced_acq_o,
    output var  logic                 armed_o,
    // Settings readback
    output var  logic [7:0]           holdoff_pct_o,
    output var  logic [WW-1:0]        upper_limit_o,
    output var  logic [WW-1:0]        lower_limit_o,
    output var  logic [SW-1:0]        level_o,
    output var  logic                 level_busy_o
);

    localparam int HW = ptq_pkg::PCT_W + TW;

    typedef enum {RUNT_IDLE, RUNT_POS, RUNT_NEG} ptq_runt_t;
    typedef enum {ACQ_ARMED, ACQ_HOLD} ptq_acq_t;

    // ********************************************************
    // Functions
    // ********************************************************
    function automatic logic pick_bit(input logic [1:0]  sel,
                                      input logic [11:0] v,
                                      input int          fld);
        return v[int'(sel) * ptq_pkg::CMP_W + fld];
    endfunction

    // Percent of the time base, in clocks
    function automatic logic [HW-1:0] scale(input logic [7:0]    p,
                                            input logic [TW-1:0] t);
        return HW'(p) * HW'(t);
    endfunction

    // ********************************************************
    // Source selection
    // ********************************************************
    logic [11:0]   cmp_raw;
    logic [11:0]   cmp_q;
    logic          lvl;
    logic          lo;
    logic          up;
    logic          lvl_d_ff;
    logic          lo_d_ff;
    logic          up_d_ff;
    logic [1:0]    src_d_ff;
    logic          src_chg;
    logic [SW-1:0] samp;

    assign cmp_raw = {input_channel_four_i, input_channel_three_i,
                      input_channel_two_i, input_channel_one_i};

    ptq_sync #(
        .WIDTH (12)
    ) u_sync (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .d_i    (cmp_raw),
        .q_o    (cmp_q)
    );

    assign lvl = pick_bit(source_i, cmp_q, ptq_pkg::CMP_LVL); // see (R1)
    assign lo  = pick_bit(source_i, cmp_q, ptq_pkg::CMP_LOW); // see (R10)
    assign up  = pick_bit(source_i, cmp_q, ptq_pkg::CMP_UP);  // see (R10)
    assign src_chg = (src_d_ff != source_i);

    always_comb begin
        unique case (source_i)
            ptq_pkg::SRC_ONE:   samp = input_channel_one_samp_i;
            ptq_pkg::SRC_TWO:   samp = input_channel_two_samp_i;
            ptq_pkg::SRC_THREE: samp = input_channel_three_samp_i;
            ptq_pkg::SRC_FOUR:  samp = input_channel_four_samp_i;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            lvl_d_ff <= 1'b0;
            lo_d_ff  <= 1'b0;
            up_d_ff  <= 1'b0;
            src_d_ff <= ptq_pkg::SRC_ONE;
        end else begin
            lvl_d_ff <= lvl;
            lo_d_ff  <= lo;
            up_d_ff  <= up;
            src_d_ff <= source_i;
        end
    end

    // ********************************************************
    // Pulse width measurement
    // ********************************************************
    logic [WW-1:0] cnt_ff;
    logic          meas_ok_ff;
    logic          pos_end;
    logic          neg_end;

    // Edges across a source switch would be bogus, so restart
    always_ff @(posedge clk_i) begin
        if (!rstn_i || src_chg) begin
            cnt_ff     <= WW'(ptq_pkg::CNT_START);
            meas_ok_ff <= 1'b0;
        end else if (lvl != lvl_d_ff) begin
            cnt_ff     <= WW'(ptq_pkg::CNT_START); // see (R21)
            meas_ok_ff <= 1'b1;
        end else if (cnt_ff != '1) begin
            cnt_ff     <= cnt_ff + WW'(1);         // see (R21)
        end
    end

    assign pos_end = meas_ok_ff & lvl_d_ff & ~lvl & ~src_chg;
    assign neg_end = meas_ok_ff & ~lvl_d_ff & lvl & ~src_chg;

    // ********************************************************
    // Glitch and width qualification
    // ********************************************************
    logic [WW-1:0] upper_ff;
    logic [WW-1:0] lower_ff;
    logic          g_cand;
    logic          g_narrow;
    logic          glitch_hit;
    logic          w_cand;
    logic          w_inside;
    logic          width_hit;

    always_comb begin
        unique case (polarity_i)                   // see (R6)
            ptq_pkg::PTQ_POS: g_cand = pos_end;
            ptq_pkg::PTQ_NEG: g_cand = neg_end;
            default:          g_cand = pos_end | neg_end;
        endcase
    end

    assign g_narrow   = (cnt_ff <= glitch_width_i);            // see (R21)
    assign glitch_hit = g_cand & (glitch_reject_i ? ~g_narrow  // see (R8)
                                                  : g_narrow); // see (R7)

    // Either has no meaning here and is read as positive
    assign w_cand = (polarity_i == ptq_pkg::PTQ_NEG) ? neg_end
                                                     : pos_end; // see (R15)
    assign w_inside  = (cnt_ff >= lower_ff)
                     && (cnt_ff <= upper_ff);         // see (R18)
    assign width_hit = w_cand & (width_outside_i ? ~w_inside  // see (R17)
                                                 : w_inside); // see (R16)

    // ********************************************************
    // Runt detection
    // ********************************************************
    ptq_runt_t runt_ff;
    ptq_runt_t nxt_runt;
    logic      runt_hit;
    logic      allow_pos;
    logic      allow_neg;

    assign allow_pos = (polarity_i != ptq_pkg::PTQ_NEG);  // see (R13)
    assign allow_neg = (polarity_i != ptq_pkg::PTQ_POS);  // see (R13)

    always_comb begin
        nxt_runt = runt_ff;
        runt_hit = 1'b0;
        unique case (runt_ff)
            RUNT_IDLE: begin
                if (allow_pos && lo && !lo_d_ff && !up) begin
                    nxt_runt = RUNT_POS;               // see (R11)
                end else if (allow_neg && !up && up_d_ff && lo) begin
                    nxt_runt = RUNT_NEG;               // see (R12)
                end
            end
            RUNT_POS: begin
                if (up) begin
                    nxt_runt = RUNT_IDLE;              // see (R11)
                end else if (!lo) begin
                    nxt_runt = RUNT_IDLE;
                    runt_hit = 1'b1;                   // see (R14)
                end
            end
            RUNT_NEG: begin
                if (!lo) begin
                    nxt_runt = RUNT_IDLE;              // see (R12)
                end else if (up) begin
                    nxt_runt = RUNT_IDLE;
                    runt_hit = 1'b1;                   // see (R14)
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i || src_chg) begin
            runt_ff <= RUNT_IDLE;
        end else begin
            runt_ff <= nxt_runt;
        end
    end

    logic qual;

    always_comb begin
        unique case (class_i)                          // see (R20)
            ptq_pkg::PTQ_GLITCH: qual = glitch_hit;
            ptq_pkg::PTQ_RUNT:   qual = runt_hit;
            ptq_pkg::PTQ_WIDTH:  qual = width_hit;
            default:             qual = 1'b0;
        endcase
    end

    // ********************************************************
    // Settings
    // ********************************************************
    logic [WW-1:0] new_up;
    logic [WW-1:0] new_lo;
    logic [7:0]    holdoff_ff;

    assign new_up = upper_wr_i ? upper_val_i : upper_ff;
    assign new_lo = lower_wr_i ? lower_val_i : lower_ff;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            upper_ff <= WW'(ptq_pkg::UPPER_RST);
            lower_ff <= WW'(ptq_pkg::LOWER_RST);
        end else if (upper_wr_i || lower_wr_i) begin
            upper_ff <= new_up;
            lower_ff <= (new_lo > new_up) ? new_up : new_lo; // see (R19)
        end
    end

    // Percent above full scale is clipped to full scale
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            holdoff_ff <= ptq_pkg::HOLDOFF_RST;
        end else if (holdoff_wr_i) begin
            holdoff_ff <= (holdoff_pct_i > ptq_pkg::PCT_MAX)
                        ? ptq_pkg::PCT_MAX : holdoff_pct_i; // see (R5)
        end
    end

    // ********************************************************
    // Acquisition control
    // ********************************************************
    ptq_acq_t      acq_ff;
    logic [HW-1:0] hold_cnt_ff;
    logic [HW-1:0] auto_cnt_ff;
    logic          force_pend_ff;
    logic          armed;
    logic          auto_due;
    logic          start;

    assign armed    = (acq_ff == ACQ_ARMED);
    assign auto_due = auto_mode_i && (auto_cnt_ff >=
                      scale(ptq_pkg::AUTO_WAIT_PCT, timebase_i)); // see (R2)
    // Normal mode has no timeout path at all
    assign start = armed & (qual | force_pend_ff | auto_due); // see (R3)

    // A new request wins over the clear of an old one
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            force_pend_ff <= 1'b0;
        end else if (force_i) begin
            force_pend_ff <= 1'b1;                     // see (R4)
        end else if (start) begin
            force_pend_ff <= 1'b0;                     // see (R4)
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            acq_ff      <= ACQ_ARMED;
            hold_cnt_ff <= '0;
        end else begin
            unique case (acq_ff)
                ACQ_ARMED: begin
                    if (start) begin
                        acq_ff      <= ACQ_HOLD;
                        hold_cnt_ff <= scale(holdoff_ff,
                                             timebase_i); // see (R5)
                    end
                end
                ACQ_HOLD: begin
                    if (hold_cnt_ff <= HW'(1)) begin
                        acq_ff <= ACQ_ARMED;           // see (R5)
                    end else begin
                        hold_cnt_ff <= hold_cnt_ff - HW'(1);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i || !armed || start) begin
            auto_cnt_ff <= '0;
        end else if (auto_cnt_ff != '1) begin
            auto_cnt_ff <= auto_cnt_ff + HW'(1);       // see (R2)
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            trig_o       <= 1'b0;
            acq_start_o  <= 1'b0;
            auto_acq_o   <= 1'b0;
            forced_acq_o <= 1'b0;
            armed_o      <= 1'b1;
        end else begin
            trig_o       <= armed & qual;
            acq_start_o  <= start;
            auto_acq_o   <= start & ~qual & ~force_pend_ff;
            forced_acq_o <= start & ~qual & force_pend_ff;
            armed_o      <= armed ? ~start : (hold_cnt_ff <= HW'(1));
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            holdoff_pct_o <= ptq_pkg::HOLDOFF_RST;
            upper_limit_o <= WW'(ptq_pkg::UPPER_RST);
            lower_limit_o <= WW'(ptq_pkg::LOWER_RST);
        end else begin
            holdoff_pct_o <= holdoff_ff;
            upper_limit_o <= upper_ff;
            lower_limit_o <= lower_ff;
        end
    end

    // ********************************************************
    // Midpoint level search
    // ********************************************************
    logic [ptq_pkg::MID_CW-1:0] mid_cnt_ff;
    logic [SW-1:0]              max_ff;
    logic [SW-1:0]              min_ff;
    logic [SW:0]                mid_sum;

    assign mid_sum = {1'b0, max_ff} + {1'b0, min_ff};

    // A request during a search is ignored, not queued
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            level_busy_o <= 1'b0;
            mid_cnt_ff   <= '0;
            max_ff       <= '0;
            min_ff       <= '0;
            level_o      <= SW'(ptq_pkg::LEVEL_RST);
        end else if (!level_busy_o) begin
            if (mid_req_i) begin
                level_busy_o <= 1'b1;
                mid_cnt_ff   <= '0;
                max_ff       <= samp;
                min_ff       <= samp;
            end
        end else begin
            if (samp > max_ff) max_ff <= samp;         // see (R9)
            if (samp < min_ff) min_ff <= samp;         // see (R9)
            if (mid_cnt_ff == ptq_pkg::MID_CW'(
                    ptq_pkg::MID_SEARCH_CYC - 1)) begin
                level_busy_o <= 1'b0;
                level_o      <= mid_sum[SW:1];         // see (R9)
            end else begin
                mid_cnt_ff <= mid_cnt_ff + ptq_pkg::MID_CW'(1);
            end
        end
    end

endmodule // ptq_qualifier
`default_nettype wire

// [ptq_qualifier_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module ptq_qualifier_chk #(
    parameter int WW = 16
) (
    input wire logic          clk_i,
    input wire logic          rstn_i,
    input wire logic          auto_mode_i,
    input wire logic          mid_req_i,
    input wire logic          trig_o,
    input wire logic          acq_start_o,
    input wire logic          auto_acq_o,
    input wire logic          forced_acq_o,
    input wire logic          armed_o,
    input wire logic [7:0]    holdoff_pct_o,
    input wire logic [WW-1:0] upper_limit_o,
    input wire logic [WW-1:0] lower_limit_o,
    input wire logic          level_busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Midpoint request taken only when idle
    sequence s_mid_take;
        mid_req_i && !level_busy_o;
    endsequence
    a_trig_starts: assert property (trig_o |-> acq_start_o)
        else $error("trigger without acquisition start");
    a_normal_quiet: assert property ((!auto_mode_i && !$past(auto_mode_i)) |-> !auto_acq_o)
        else $error("auto start in normal mode");
    a_auto_only: assert property (auto_acq_o |-> acq_start_o && !trig_o && !forced_acq_o)
        else $error("auto start flag wrong");
    a_force_excl: assert property (forced_acq_o |-> acq_start_o && !trig_o)
        else $error("forced start flag wrong");
    a_one_start: assert property (acq_start_o |=> !acq_start_o)
        else $error("back to back starts");
    a_start_disarm: assert property (acq_start_o |-> !armed_o)
        else $error("still armed at start");
    a_trig_armed: assert property (trig_o |-> $past(armed_o))
        else $error("trigger while not armed");
    a_holdoff_clip: assert property (holdoff_pct_o <= 8'h64)
        else $error("holdoff above 100");
    a_lower_clamp: assert property (lower_limit_o <= upper_limit_o)
        else $error("lower limit above upper");
    a_mid_busy: assert property (s_mid_take |=> level_busy_o [*8])
        else $error("midpoint search idle");
endmodule // ptq_qualifier_chk
`default_nettype wire

// [ptq_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module ptq_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    // Asynchronous in, synchronised out
    input  wire logic [WIDTH-1:0] d_i,
    output var  logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_ff;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            meta_ff <= '0;
            q_o     <= '0;
        end else begin
            meta_ff <= d_i;
            q_o     <= meta_ff;
        end
    end

endmodule // ptq_sync
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int WW = 16;
    localparam logic [7:0] LO = 8'h20, MD = 8'ha0, HI = 8'he0;
    localparam ptq_pkg::ptq_class_t GL = ptq_pkg::PTQ_GLITCH;
    localparam ptq_pkg::ptq_class_t WD = ptq_pkg::PTQ_WIDTH;
    localparam ptq_pkg::ptq_pol_t PP = ptq_pkg::PTQ_POS;
    localparam ptq_pkg::ptq_pol_t PN = ptq_pkg::PTQ_NEG;
    localparam ptq_pkg::ptq_pol_t PE = ptq_pkg::PTQ_EITHER;
    typedef struct {
        ptq_pkg::ptq_class_t cls;
        ptq_pkg::ptq_pol_t   pol;
        logic                rej;
        logic                outs;
        logic                neg;
        int                  w;
        logic                exp;
    } ptq_row_t;
    ptq_row_t rows [13] = '{
        '{GL, PP, 0, 0, 0, 4, 1}, '{GL, PP, 0, 0, 0, 5, 0},
        '{GL, PP, 1, 0, 0, 5, 1}, '{GL, PP, 1, 0, 0, 4, 0},
        '{GL, PN, 0, 0, 1, 2, 1}, '{GL, PN, 0, 0, 0, 2, 0},
        '{GL, PE, 0, 0, 1, 3, 1}, '{WD, PP, 0, 0, 0, 3, 1},
        '{WD, PP, 0, 0, 0, 2, 0}, '{WD, PP, 0, 0, 0, 6, 1},
        '{WD, PP, 0, 0, 0, 7, 0}, '{WD, PP, 0, 1, 0, 7, 1},
        '{WD, PN, 0, 0, 1, 4, 1}};
    logic [7:0]  rb [6] = '{LO, LO, HI, HI, LO, HI};
    logic [7:0]  rp [6] = '{MD, HI, MD, LO, MD, MD};
    ptq_pkg::ptq_pol_t rpol [6] = '{PP, PP, PN, PN, PE, PE};
    int          rhit [6] = '{3, 0, 3, 0, 3, 3};
    logic clk_i = 1'b0, rstn_i = 1'b0;
    logic [7:0] v [4];
    logic [2:0] cmp [4];
    logic [1:0] source_i = 2'h0;
    ptq_pkg::ptq_class_t class_i = GL;
    ptq_pkg::ptq_pol_t   polarity_i = PP;
    logic glitch_reject_i = 1'b0, width_outside_i = 1'b0;
    logic auto_mode_i = 1'b0, force_i = 1'b0, mid_req_i = 1'b0;
    logic holdoff_wr_i = 1'b0, upper_wr_i = 1'b0, lower_wr_i = 1'b0;
    logic [15:0] glitch_width_i = 16'h0004, timebase_i = 16'h0001;
    logic [15:0] upper_val_i = 16'h0000, lower_val_i = 16'h0000;
    logic [7:0]  holdoff_pct_i = 8'h00;
    logic trig_o, acq_start_o, auto_acq_o, forced_acq_o, armed_o;
    logic level_busy_o;
    logic [7:0]  holdoff_pct_o, level_o;
    logic [15:0] upper_limit_o, lower_limit_o;
    int err_total = 0, n_checks = 0, hit, n, m;

    always #25 clk_i = ~clk_i;

    ptq_afe u_afe (.v_i(v), .cmp_o(cmp));
    ptq_qualifier #(.WW(WW), .SW(8), .TW(16)) uut (
        .clk_i, .rstn_i,
        .input_channel_one_i(cmp[0]), .input_channel_two_i(cmp[1]),
        .input_channel_three_i(cmp[2]), .input_channel_four_i(cmp[3]),
        .input_channel_one_samp_i(v[0]), .input_channel_two_samp_i(v[1]),
        .input_channel_three_samp_i(v[2]),
        .input_channel_four_samp_i(v[3]),
        .source_i, .class_i, .polarity_i, .glitch_reject_i, .glitch_width_i,
        .width_outside_i, .auto_mode_i, .timebase_i, .holdoff_wr_i,
        .holdoff_pct_i, .upper_wr_i, .upper_val_i, .lower_wr_i, .lower_val_i,
        .force_i, .mid_req_i, .trig_o, .acq_start_o, .auto_acq_o,
        .forced_acq_o, .armed_o, .holdoff_pct_o, .upper_limit_o,
        .lower_limit_o, .level_o, .level_busy_o);

    // ********************************************************
    // Tasks
    // ********************************************************
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (err_total == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Real edges slew, so runt tests pass through the middle band
    task automatic step(input int c, input logic [7:0] x, input logic r);
        if (r) begin
            v[c] <= MD;
            @(posedge clk_i);
        end
        v[c] <= x;
        @(posedge clk_i);
    endtask
    task automatic pulse(input int c, input logic [7:0] b,
                         input logic [7:0] p, input int w, input logic r);
        @(posedge clk_i);
        step(c, b, r);
        repeat (20) @(posedge clk_i);
        step(c, p, r);
        repeat (w - 1) @(posedge clk_i);
        step(c, b, r);
        hit = 0;
        for (int i = 2; i <= 9; i++) begin
            @(posedge clk_i);
            #1;
            if (trig_o === 1'b1 && hit == 0) hit = i;
        end
    endtask
    task automatic wr(input int s, input logic [15:0] d);
        @(posedge clk_i);
        upper_wr_i <= s == 0;
        lower_wr_i <= s == 1;
        holdoff_wr_i <= s == 2;
        {upper_val_i, lower_val_i, holdoff_pct_i} <= {d, d, d[7:0]};
        @(posedge clk_i);
        {upper_wr_i, lower_wr_i, holdoff_wr_i} <= 3'h0;
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    task automatic count(input int cyc);
        n = 0;
        m = 0;
        repeat (cyc) begin
            @(posedge clk_i);
            #1;
            n += (acq_start_o === 1'b1) + (forced_acq_o === 1'b1);
            m += (armed_o === 1'b0) + 1000 * (auto_acq_o === 1'b1);
        end
    endtask

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        foreach (v[i]) v[i] = LO;
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        #1;
        chk({armed_o, level_busy_o, holdoff_pct_o, upper_limit_o,
             lower_limit_o, level_o}, {2'h2, 8'h00, 16'hffff, 16'h0000,
             8'h80});
        wr(0, 16'h0006);
        wr(1, 16'h0009);
        chk(lower_limit_o, 16'h0006);
        wr(1, 16'h0003);
        wr(2, 16'h00c8);
        chk(holdoff_pct_o, 8'h64);
        @(posedge clk_i);
        force_i <= 1'b1;
        @(posedge clk_i);
        force_i <= 1'b0;
        count(130);
        chk({n, m}, {32'd2, 32'd100});
        wr(2, 16'h0000);
        foreach (rows[k]) begin
            @(posedge clk_i);
            {class_i, polarity_i} <= {rows[k].cls, rows[k].pol};
            glitch_reject_i <= rows[k].rej;
            width_outside_i <= rows[k].outs;
            pulse(0, rows[k].neg ? HI : LO, rows[k].neg ? LO : HI,
                  rows[k].w, 1'b0);
            chk(hit != 0, rows[k].exp);
        end
        {class_i, polarity_i, width_outside_i} <= {GL, PP, 1'b0};
        for (int s = 0; s < 4; s++) begin
            source_i <= 2'(s);
            pulse((s + 1) % 4, LO, HI, 2, 1'b0);
            chk(hit, 0);
            pulse(s, LO, HI, 2, 1'b0);
            chk(hit != 0, 1);
        end
        source_i <= 2'h0;
        class_i <= ptq_pkg::PTQ_RUNT;
        for (int k = 0; k < 6; k++) begin
            polarity_i <= rpol[k];
            pulse(0, rb[k], rp[k], 3, 1'b1);
            chk(hit, rhit[k]);
        end
        count(250);
        chk(n, 0);
        auto_mode_i <= 1'b1;
        count(250);
        chk(m / 1000 >= 2 && m / 1000 <= 3, 1);
        auto_mode_i <= 1'b0;
        @(posedge clk_i);
        v[0] <= 8'h10;
        mid_req_i <= 1'b1;
        @(posedge clk_i);
        mid_req_i <= 1'b0;
        repeat (500) @(posedge clk_i);
        v[0] <= 8'hd0;
        repeat (500) @(posedge clk_i);
        v[0] <= 8'h40;
        n = 0;
        while (level_busy_o !== 1'b0 && n < 2100) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk(level_o, 8'h70);
        give_verdict();
    end

    initial begin
        #500000;
        err_total++;
        give_verdict();
    end
endmodule // tb_top

bind ptq_qualifier ptq_qualifier_chk #(.WW(WW)) u_chk (
    .clk_i, .rstn_i, .auto_mode_i, .mid_req_i, .trig_o, .acq_start_o,
    .auto_acq_o, .forced_acq_o, .armed_o, .holdoff_pct_o, .upper_limit_o,
    .lower_limit_o, .level_busy_o);
`default_nettype wire
